// ==== pkg/aeb_pkg.sv ====
// package: constants, carriers and state codes of the asynchronous external bus master
package aeb_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int AEB_CLK_MHZ = 250;          // core clock rate
  localparam int AEB_STATE_NS = 20;          // one bus state = half a period of the clock output
  // whole core cycles per bus state, never less than one
  localparam int AEB_STATE_CYCLES = ((AEB_STATE_NS * AEB_CLK_MHZ) / 1000) < 1 ? 1 :
                                    ((AEB_STATE_NS * AEB_CLK_MHZ) / 1000);
  localparam int AEB_MONITOR_MAX = 64;       // longest bus monitor period, clock-output periods

  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] AEB_SIZE_LONG = 2'h0;
  localparam logic [1:0] AEB_SIZE_BYTE = 2'h1;
  localparam logic [1:0] AEB_SIZE_WORD = 2'h2;
  localparam logic [1:0] AEB_SIZE_THREE = 2'h3;
  localparam logic [2:0] AEB_SPACE_CPU = 3'h7;     // space holding interrupt acknowledge cycles
  localparam logic [23:0] AEB_ADDR_RESET = 24'h000000;
  localparam logic [2:0] AEB_SPACE_RESET = 3'h0;
  localparam logic [1:0] AEB_SIZE_RESET = AEB_SIZE_LONG;
  localparam logic AEB_RW_RESET = 1'b1;             // direction rests at read
  localparam logic [6:0] AEB_MON_RESET = 7'h00;
  localparam int AEB_SYNC_W = 21;                   // 16 data + 5 control inputs

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic write;            // 1 = write cycle
    logic [23:0] addr;      // address of most significant byte moved
    logic [1:0] size;       // operand bytes still to move
    logic [2:0] space;      // address space code
    logic [15:0] wdata;     // write data, already placed on its lanes
  } aeb_req_t;

  typedef struct packed {
    logic [15:0] rdata;     // data captured on a read
    logic port8;            // responder reported an 8-bit port
    logic fault;            // cycle ended by bus fault (external or monitor)
    logic timeout;          // fault came from the bus monitor
    logic retry;            // fault and halt together: repeat the cycle
    logic autovec;          // ended by autovector
  } aeb_rsp_t;

  typedef struct packed {
    logic ack_hi_n;
    logic ack_lo_n;
    logic fault_n;
    logic halt_n;
    logic auto_vector_n_n;
  } aeb_ctl_in_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_S0 = 7'h02,
    ST_S1 = 7'h04,
    ST_S2 = 7'h08,
    ST_WAIT = 7'h10,
    ST_S3 = 7'h20,
    ST_S4 = 7'h40
  } aeb_state_e_t;

endpackage : aeb_pkg

// ==== hw/aeb_state_tick.sv ====
// module: divider making the clock output and one-cycle enables at its edges
`timescale 1ns/100ps
`default_nettype none

module aeb_state_tick
  import aeb_pkg::*;
#(
  parameter int STATE_CYCLES = AEB_STATE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  output logic clk_level,
  output logic rise_en,
  output logic fall_en
);

  typedef struct packed {
    logic [15:0] cnt;
    logic level;
    logic rise;
    logic fall;
  } aeb_tick_t;

  localparam logic [15:0] LAST = 16'(STATE_CYCLES - 1);

  aeb_tick_t s_q, s_d;

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  // each wrap ends one bus state; the enables line up with the output change
  always_comb begin
    s_d = s_q;
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    if (s_q.cnt == LAST) begin
      s_d.cnt = 16'h0000;
      s_d.level = ~s_q.level;
      s_d.rise = ~s_q.level;
      s_d.fall = s_q.level;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_level = s_q.level;
  assign rise_en = s_q.rise;
  assign fall_en = s_q.fall;

endmodule : aeb_state_tick

`default_nettype wire

// ==== hw/aeb_input_sync.sv ====
// module: two-stage resolver for the bus inputs
`timescale 1ns/100ps
`default_nettype none

module aeb_input_sync #(
  parameter int W = 21,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } aeb_sync_t;

  aeb_sync_t s_q, s_d;

  // ---------------------------------------------------------------
  // resolve
  // ---------------------------------------------------------------
  // only the second stage is visible, so a level caught mid-change settles first
  always_comb begin
    s_d.meta = din;
    s_d.safe = s_q.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.meta <= RESET_VAL;
      s_q.safe <= RESET_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.safe;

endmodule : aeb_input_sync

`default_nettype wire

// ==== hw/aeb_bus_master.sv ====
// module: master end of the asynchronous external bus, one bus cycle per request
//
// Functional notes
// - Address of most significant byte driven at cycle start, held through address strobe.
// - Address strobe asserts half a clock-output period after the cycle starts.
// - Data bus is 16 bits, two-way, carrying 8 or 16 bits per cycle.
// - Read data is captured on the last falling edge of the cycle.
// - Write data is driven half a period after address strobe asserts.
// - On reads data strobe asserts together with address strobe.
// - On writes data strobe asserts one full period after address strobe.
// - Direction changes only at cycle start, when the direction actually differs.
// - Transfer size shows bytes still to move, valid during address strobe.
// - Three space-code outputs extend the address to eight spaces.
// - Responder asserts a size acknowledge giving port width; that ends the cycle.
// - Bus fault without acknowledge is an error; with acknowledge it is still an error.
// - Halt forces single cycles; fault plus halt ends the cycle as retry.
// - Autovector ends an interrupt acknowledge cycle; vector made internally.
// - An acknowledged cycle takes at least three clock-output periods.
// - Without acknowledge, wait states are added one full period at a time.
// - Bus monitor faults the cycle after at most 64 periods; always on.
// - Every input is resolved clean and sampled at falling clock-output edges; halt is also sampled at the rising edge that would start a cycle.
// - Read data is captured on the falling edge after acknowledge is seen.
// - Acknowledge seen at end of state 2 gives a three-period cycle.
// - Acknowledge code: 11 wait, 10 eight-bit, 01 sixteen-bit, 00 sixteen-bit.
// - Size code: 01 byte, 10 word, 11 three bytes, 00 long word.
`timescale 1ns/100ps
`default_nettype none

module aeb_bus_master
  import aeb_pkg::*;
#(
  parameter int STATE_CYCLES = AEB_STATE_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  // user side
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire aeb_req_t REQ,
  output logic RSP_VALID,
  output aeb_rsp_t RSP,
  input wire logic [5:0] MONITOR_PERIOD,
  // bus side
  output logic SYSTEM_CLOCK_OUTPUT,
  output logic [23:0] ADDR,
  output logic [2:0] SPACE_CODE,
  output logic [1:0] TRANSFER_SIZE,
  output logic READ_WRITE,
  output logic ADDRESS_STROBE_N,
  output logic DATA_STROBE_N,
  input wire logic [15:0] DATA_I,
  output logic [15:0] DATA_O,
  output logic DATA_OE,
  input wire logic SIZE_ACK_HI_N,
  input wire logic SIZE_ACK_LO_N,
  input wire logic BUS_FAULT_N,
  input wire logic HALT_N,
  input wire logic AUTO_VECTOR_N
);

  // ---------------------------------------------------------------
  // types and helpers
  // ---------------------------------------------------------------
  typedef struct packed {
    aeb_state_e_t st;
    aeb_req_t req;          // request being run on the bus
    logic rw;               // direction pin level, high = read
    logic as_n;
    logic ds_n;
    logic oe;
    logic [15:0] dout;
    logic [6:0] mon;        // clock-output periods spent waiting
    logic rsp_valid;
    aeb_rsp_t rsp;
  } aeb_master_t;

  typedef struct packed {
    logic done;
    logic port8;
  } aeb_ack_t;

  // decode of the two acknowledge lines; reserved 00 counts as a 16-bit port
  function automatic aeb_ack_t ack_decode(input logic hi_n, input logic lo_n);
    aeb_ack_t a;
    a.done = ~(hi_n & lo_n);
    a.port8 = hi_n & ~lo_n;
    return a;
  endfunction : ack_decode

  // ---------------------------------------------------------------
  // clock output and input sampling
  // ---------------------------------------------------------------
  logic clk_level;
  logic rise_en;
  logic fall_en;
  logic [AEB_SYNC_W-1:0] raw_in;
  logic [AEB_SYNC_W-1:0] clean_in;
  logic [15:0] data_in;
  aeb_ctl_in_t ctl_in;
  aeb_ack_t ack;
  logic [6:0] mon_limit;
  logic [6:0] mon_next;

  aeb_state_tick #(
    .STATE_CYCLES(STATE_CYCLES)
  ) u_tick (
    .clk(CLK),
    .rst(RST),
    .clk_level(clk_level),
    .rise_en(rise_en),
    .fall_en(fall_en)
  );

  // every input, data included, goes through the same resolver so a level
  // that moves near the sample point is never used half-settled
  assign raw_in = {DATA_I, SIZE_ACK_HI_N, SIZE_ACK_LO_N, BUS_FAULT_N, HALT_N, AUTO_VECTOR_N};

  aeb_input_sync #(
    .W(AEB_SYNC_W),
    .RESET_VAL({16'h0000, 5'h1f})
  ) u_sync (
    .clk(CLK),
    .rst(RST),
    .din(raw_in),
    .dout(clean_in)
  );

  assign data_in = clean_in[20:5];
  assign ctl_in = aeb_ctl_in_t'(clean_in[4:0]);
  assign ack = ack_decode(ctl_in.ack_hi_n, ctl_in.ack_lo_n);

  // monitor period field holds period minus one, so the longest is 64
  assign mon_limit = {1'b0, MONITOR_PERIOD} + 7'h01;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  aeb_master_t s_q, s_d;

  // a new cycle may start only on a rising clock-output edge, only when the
  // previous one is fully over, and never while halt is held
  assign REQ_READY = (s_q.st == ST_IDLE) && rise_en && ctl_in.halt_n;

  assign mon_next = s_q.mon + 7'h01;

  // ---------------------------------------------------------------
  // bus cycle sequencer
  // ---------------------------------------------------------------
  // states are named for the half period just entered; inputs are looked at
  // on falling enables, halt also on the rising enable that starts a cycle;
  // outputs move on the matching edge
  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        if (REQ_VALID && REQ_READY) begin
          s_d.req = REQ;
          s_d.rw = ~REQ.write;
          s_d.mon = AEB_MON_RESET;
          s_d.rsp = '0;
          s_d.st = ST_S0;
        end
      end
      ST_S0: begin
        if (fall_en) begin
          s_d.as_n = 1'b0;
          s_d.ds_n = s_q.req.write;
          s_d.st = ST_S1;
        end
      end
      ST_S1: begin
        if (rise_en) begin
          if (s_q.req.write) begin
            s_d.oe = 1'b1;
            s_d.dout = s_q.req.wdata;
          end
          s_d.st = ST_S2;
        end
      end
      ST_S2: begin
        // end of state 2, or end of a wait state: decide how the cycle ends
        if (fall_en) begin
          s_d.ds_n = 1'b0;
          if (!ctl_in.fault_n) begin
            // fault wins over an acknowledge seen on the same edge
            s_d.rsp.fault = 1'b1;
            s_d.rsp.retry = ~ctl_in.halt_n;
            s_d.st = ST_S3;
          end else if (ack.done) begin
            s_d.rsp.port8 = ack.port8;
            s_d.st = ST_S3;
          end else if (!ctl_in.auto_vector_n_n && s_q.req.space == AEB_SPACE_CPU) begin
            s_d.rsp.autovec = 1'b1;
            s_d.st = ST_S3;
          end else if (mon_next >= mon_limit) begin
            // the monitor cannot be turned off, so a silent bus never hangs
            s_d.rsp.fault = 1'b1;
            s_d.rsp.timeout = 1'b1;
            s_d.st = ST_S3;
          end else begin
            s_d.mon = mon_next;
            s_d.st = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // one whole clock-output period per wait state
        if (rise_en) begin
          s_d.st = ST_S2;
        end
      end
      ST_S3: begin
        if (rise_en) begin
          s_d.st = ST_S4;
        end
      end
      ST_S4: begin
        // last falling edge: capture, negate strobes, let go of the bus
        if (fall_en) begin
          if (!s_q.req.write) begin
            s_d.rsp.rdata = data_in;
          end
          s_d.as_n = 1'b1;
          s_d.ds_n = 1'b1;
          s_d.oe = 1'b0;
          s_d.rsp_valid = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        // a corrupted code drops back to a quiet bus
        s_d.st = ST_IDLE;
        s_d.as_n = 1'b1;
        s_d.ds_n = 1'b1;
        s_d.oe = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q.st <= ST_IDLE;
      s_q.req.write <= 1'b0;
      s_q.req.addr <= AEB_ADDR_RESET;
      s_q.req.size <= AEB_SIZE_RESET;
      s_q.req.space <= AEB_SPACE_RESET;
      s_q.req.wdata <= 16'h0000;
      s_q.rw <= AEB_RW_RESET;
      s_q.as_n <= 1'b1;
      s_q.ds_n <= 1'b1;
      s_q.oe <= 1'b0;
      s_q.dout <= 16'h0000;
      s_q.mon <= AEB_MON_RESET;
      s_q.rsp_valid <= 1'b0;
      s_q.rsp <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // address, size, space and direction hold between cycles, so direction
  // only moves when a new cycle goes the other way
  assign SYSTEM_CLOCK_OUTPUT = clk_level;
  assign ADDR = s_q.req.addr;
  assign SPACE_CODE = s_q.req.space;
  assign TRANSFER_SIZE = s_q.req.size;
  assign READ_WRITE = s_q.rw;
  assign ADDRESS_STROBE_N = s_q.as_n;
  assign DATA_STROBE_N = s_q.ds_n;
  assign DATA_O = s_q.dout;
  assign DATA_OE = s_q.oe;
  assign RSP_VALID = s_q.rsp_valid;
  assign RSP = s_q.rsp;

endmodule : aeb_bus_master

`default_nettype wire

// ==== bench/aeb_bus_master_assertions.sv ====
// checker: cycle timing and strobe relations of the bus master, bound to its ports
`timescale 1ns/100ps
`default_nettype none

module aeb_bus_master_assertions
  import aeb_pkg::*;
#(
  parameter int STATE_CYCLES = AEB_STATE_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire aeb_rsp_t RSP,
  input wire logic [5:0] MONITOR_PERIOD,
  input wire logic [2:0] SPACE_CODE,
  input wire logic [23:0] ADDR,
  input wire logic [1:0] TRANSFER_SIZE,
  input wire logic READ_WRITE,
  input wire logic ADDRESS_STROBE_N,
  input wire logic DATA_STROBE_N,
  input wire logic DATA_OE,
  input wire logic HALT_N
);
  // ---------------------------------------------------------------
  // cycle counter since the last take
  // ---------------------------------------------------------------
  localparam int SC = STATE_CYCLES;
  logic [11:0] cyc_q;
  logic [11:0] cyc_d;
  int cyc;
  assign cyc = int'(cyc_q);
  // saturates so a long idle stretch never wraps into a false match
  always_comb begin
    cyc_d = (cyc_q == 12'hfff) ? cyc_q : cyc_q + 12'h001;
    if (REQ_VALID && REQ_READY) cyc_d = 12'h000;
  end
  always_ff @(posedge CLK) begin
    cyc_q <= RST ? 12'h000 : cyc_d;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_as_held;
    !ADDRESS_STROBE_N ##1 !ADDRESS_STROBE_N;
  endsequence
  sequence s_cycle_end;
    $rose(ADDRESS_STROBE_N);
  endsequence

  as_delay_a: assert property ($fell(ADDRESS_STROBE_N) |-> cyc == SC)
    else $error("address strobe late or early");
  rd_strobe_a: assert property ($fell(ADDRESS_STROBE_N) && READ_WRITE |-> $fell(DATA_STROBE_N))
    else $error("read data strobe not with address strobe");
  wr_strobe_a: assert property ($fell(DATA_STROBE_N) && !READ_WRITE |-> cyc == 3 * SC)
    else $error("write data strobe timing wrong");
  wr_data_a: assert property ($rose(DATA_OE) |-> !READ_WRITE && cyc == 2 * SC)
    else $error("write data driven at wrong time");
  addr_hold_a: assert property (s_as_held |-> $stable({ADDR, SPACE_CODE, TRANSFER_SIZE, READ_WRITE}))
    else $error("address or control moved under strobe");
  dir_change_a: assert property ($changed(READ_WRITE) |-> cyc == 0)
    else $error("direction changed outside cycle start");
  cycle_len_a: assert property (s_cycle_end |-> cyc >= 5 * SC && (cyc - 5 * SC) % (2 * SC) == 0)
    else $error("cycle length not whole periods");
  release_a: assert property (s_cycle_end |-> $rose(DATA_STROBE_N) && !DATA_OE)
    else $error("strobes or data not released at cycle end");
  idle_bus_a: assert property (REQ_READY |-> ADDRESS_STROBE_N && DATA_STROBE_N && !DATA_OE)
    else $error("new cycle offered while bus busy");
  monitor_a: assert property (!ADDRESS_STROBE_N |-> cyc <= 2 * SC * (int'(MONITOR_PERIOD) + 4))
    else $error("bus monitor let cycle run too long");
  halt_block_a: assert property (!HALT_N [*3] |-> !REQ_READY)
    else $error("cycle offered during halt");
  auto_vector_n_space_a: assert property (RSP_VALID && RSP.autovec |-> SPACE_CODE == AEB_SPACE_CPU)
    else $error("autovector outside cpu space");
endmodule : aeb_bus_master_assertions

bind aeb_bus_master aeb_bus_master_assertions #(.STATE_CYCLES(STATE_CYCLES)) i_chk (
  .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP(RSP),
  .MONITOR_PERIOD(MONITOR_PERIOD), .SPACE_CODE(SPACE_CODE), .ADDR(ADDR), .TRANSFER_SIZE(TRANSFER_SIZE),
  .READ_WRITE(READ_WRITE), .ADDRESS_STROBE_N(ADDRESS_STROBE_N), .DATA_STROBE_N(DATA_STROBE_N),
  .DATA_OE(DATA_OE), .HALT_N(HALT_N)
);
`default_nettype wire

// ==== bench/aeb_peripheral.sv ====
// partner: behavioural peripheral answering the bus master
`timescale 1ns/100ps
`default_nettype none

module aeb_peripheral
  import aeb_pkg::*;
(
  input wire logic clk,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  input wire logic [23:0] addr,
  input wire logic [15:0] data_o,
  input wire logic data_oe,
  input wire logic [7:0] delay,
  input wire logic [1:0] ack_code,
  input wire logic fault,
  output logic [15:0] data_i,
  output logic size_ack_hi_n,
  output logic size_ack_lo_n,
  output logic bus_fault_n,
  output logic [15:0] wr_data
);
  // ---------------------------------------------------------------
  // response
  // ---------------------------------------------------------------
  logic [7:0] cnt_q = 8'h00;
  logic [15:0] junk_q = 16'h0ff0;
  logic resp;
  // answer after the chosen wait, held until the strobes negate
  assign resp = !data_strobe_n && !address_strobe_n && cnt_q >= delay;
  always_ff @(posedge clk) begin
    cnt_q <= data_strobe_n ? 8'h00 : cnt_q + 8'h01;
    junk_q <= ~junk_q;
    if (resp && !read_write && data_oe) wr_data <= data_o;
  end
  assign {size_ack_hi_n, size_ack_lo_n} = resp ? ack_code : 2'h3;
  assign bus_fault_n = !(resp && fault);
  // the bus toggles while neither side drives data, so a late capture cannot pass by luck
  assign data_i = data_oe ? data_o : (!data_strobe_n && read_write) ? addr[15:0] ^ 16'h5a3c : junk_q;
endmodule : aeb_peripheral
`default_nettype wire

// ==== bench/testbench.sv ====
// testbench: directed and random bus cycles against a behavioural peripheral
`timescale 1ns/100ps
`default_nettype none

module testbench
  import aeb_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  aeb_req_t req = '0;
  logic [5:0] mon = 6'h3f;
  logic halt_n = 1'b1;
  logic auto_vector_n_n = 1'b1;
  logic [7:0] dly = 8'h00;
  logic [1:0] code = 2'h1;
  logic flt = 1'b0;
  logic rdy, rvld, rw, as_n, ds_n, oe, hi_n, lo_n, bf_n;
  logic clko;
  logic clko_p = 1'b0;
  logic [23:0] addr;
  logic [2:0] space;
  logic [1:0] size;
  logic [15:0] din, dout, wr_data;
  aeb_rsp_t rsp;
  aeb_rsp_t exp_q[$];
  aeb_rsp_t msk_q[$];
  logic [16:0] wr_q[$];
  logic [1:0] codes [3] = '{2'h1, 2'h2, 2'h0};
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 3;
  aeb_req_t r;

  initial begin
    forever #2 clk = ~clk;
  end

  aeb_bus_master #(.STATE_CYCLES(1)) i_dut (
    .CLK(clk), .RST(rst), .REQ_VALID(req_valid), .REQ_READY(rdy), .REQ(req), .RSP_VALID(rvld), .RSP(rsp),
    .MONITOR_PERIOD(mon), .SYSTEM_CLOCK_OUTPUT(clko), .ADDR(addr), .SPACE_CODE(space), .TRANSFER_SIZE(size),
    .READ_WRITE(rw), .ADDRESS_STROBE_N(as_n), .DATA_STROBE_N(ds_n), .DATA_I(din), .DATA_O(dout), .DATA_OE(oe),
    .SIZE_ACK_HI_N(hi_n), .SIZE_ACK_LO_N(lo_n), .BUS_FAULT_N(bf_n), .HALT_N(halt_n), .AUTO_VECTOR_N(auto_vector_n_n)
  );

  aeb_peripheral i_peer (
    .clk(clk), .address_strobe_n(as_n), .data_strobe_n(ds_n), .read_write(rw), .addr(addr), .data_o(dout),
    .data_oe(oe), .delay(dly), .ack_code(code), .fault(flt), .data_i(din), .size_ack_hi_n(hi_n),
    .size_ack_lo_n(lo_n), .bus_fault_n(bf_n), .wr_data(wr_data)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // one bus cycle: note the outcome, hand the request over, hold halt or autovector while it runs
  task automatic run(input aeb_req_t q, input logic [7:0] dl, input logic [1:0] cd, input logic ft,
                     input logic [1:0] hv, input logic [3:0] f);
    aeb_rsp_t e;
    int n;
    e = '0;
    e.rdata = q.addr[15:0] ^ 16'h5a3c;
    e.port8 = (cd == 2'h2);
    {e.fault, e.timeout, e.retry, e.autovec} = f;
    exp_q.push_back(e);
    msk_q.push_back(f != 4'h0 ? 21'hf : q.write ? 21'h1f : 21'h1fffff);
    wr_q.push_back({q.write && f == 4'h0, q.wdata});
    @(posedge clk);
    req <= q;
    req_valid <= 1'b1;
    dly <= dl;
    code <= cd;
    flt <= ft;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 100);
    @(posedge clk);
    req_valid <= 1'b0;
    halt_n <= !hv[1];
    auto_vector_n_n <= !hv[0];
    for (n = 0; n < 20 && as_n !== 1'b0; n++) @(negedge clk);
    check(32'({addr, space, size, rw}), 32'({q.addr, q.space, q.size, !q.write}));
    for (n = 0; n < 400 && exp_q.size() != 0; n++) @(negedge clk);
    @(posedge clk);
    halt_n <= 1'b1;
    auto_vector_n_n <= 1'b1;
  endtask : run

  // response watcher: the oldest note belongs to the cycle that just ended
  always @(negedge clk) begin
    if (rvld === 1'b1) begin
      check(32'(rsp & msk_q[0]), 32'(exp_q[0] & msk_q[0]));
      if (wr_q[0][16]) begin
        check(32'(wr_data), 32'(wr_q[0][15:0]));
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
      void'(wr_q.pop_front());
    end
  end

  // clock output must toggle every core cycle with one-cycle states, so sampling edges exist
  always @(negedge clk) begin
    if (cycles > 20) check(32'(clko == clko_p), 32'h0);
    clko_p = clko;
  end

  // hang guard, far above the thousand or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // every acknowledge code, read and write, with a short and a longer wait
    for (int i = 0; i < 12; i++) begin
      r = aeb_req_t'(46'({$random(seed), $random(seed)}));
      r.write = i[0];
      run(r, 8'((i / 6) * 3), codes[i % 3], 1'b0, 2'h0, 4'h0);
    end
    // silent responder: the monitor ends the cycle, shortest and a longer period
    mon <= 6'h00;
    run(r, 8'h00, 2'h3, 1'b0, 2'h0, 4'hc);
    mon <= 6'h05;
    r.write = 1'b0;
    run(r, 8'h00, 2'h3, 1'b0, 2'h0, 4'hc);
    mon <= 6'h3f;
    run(r, 8'h02, 2'h3, 1'b1, 2'h0, 4'h8);
    run(r, 8'h00, 2'h1, 1'b1, 2'h0, 4'h8);
    run(r, 8'h03, 2'h3, 1'b1, 2'h2, 4'ha);
    r.space = AEB_SPACE_CPU;
    run(r, 8'h00, 2'h3, 1'b0, 2'h1, 4'h1);
    // random traffic back to back
    for (int i = 0; i < 40; i++) begin
      r = aeb_req_t'(46'({$random(seed), $random(seed)}));
      run(r, 8'($unsigned($random(seed)) % 5), codes[$unsigned($random(seed)) % 3], 1'b0, 2'h0, 4'h0);
    end
    test_done();
  end
endmodule : testbench
`default_nettype wire
